/* logic/mtu_pkg.sv */
// Behaviour
// - 8-bit up-counter, free-running or limited by a programmable modulo value.
// - Overflow interrupt enabled by software gives periodic interrupt requests.
// - Prescaler source: bus clock, fixed clock, pin rising or pin falling edge.
// - Prescaler divides the source by 1,2,4,...,256 chosen by prescale select.
// - Source select 1:1 picks pin rising edge, 1:0 picks pin falling edge.
// - The count pin may feed this timer and the pulse-width timer together.
// - A gate bit, set by reset, switches the timer clock; clearing saves power.
// - An enabled timer keeps counting in wait; its interrupt can wake the core.
// - Timer disabled in every stop state and never wakes from stop.
// - Waking from deep stop, or light stop by reset, returns timer to reset.
// - Leaving light stop by interrupt keeps state; counting resumes from held value.
// - Background debug suspends counting; resume from held value unless cleared.
// - The external count pin is synchronised to the bus clock before use.
// - Four 8-bit registers: status/control, clock config, count, modulo limit.
// - Overflow flag sets on roll to 0x00 after modulo; interrupt while enabled.
// - Flag cleared by read-while-set then write 0, by counter clear or modulo write.
// - Writing 1 to counter clear zeroes count and flag; the bit reads 0.
// - Halt bit freezes the count while set; reset sets the halt bit.
package mtu_pkg;
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
    localparam logic [3:0] OFS_CURRENT_COUNT  = 4'h8;
    localparam logic [3:0] OFS_MODULO_LIMIT   = 4'hC;
    localparam int BIT_OVERFLOW_FLAG   = 7;
    localparam int BIT_OVERFLOW_IRQ_EN = 6;
    localparam int BIT_COUNTER_CLEAR   = 5;
    localparam int BIT_COUNTER_HALT    = 4;
    localparam int POS_SOURCE_SELECT   = 4;
    localparam logic [1:0] SRC_BUS       = 2'h0;
    localparam logic [1:0] SRC_FIXED     = 2'h1;
    localparam logic [1:0] SRC_PIN_FALL  = 2'h2;
    localparam logic [1:0] SRC_PIN_RISE  = 2'h3;
    localparam logic [3:0] PRESCALE_MAX  = 4'h8;
    localparam logic [7:0] RST_COUNT     = 8'h00;
    localparam logic [7:0] RST_MODULO    = 8'h00;
    localparam logic [5:0] RST_CLOCK_CFG = 6'h00;

    typedef struct packed {
        logic       deep_halt_level_one;
        logic       deep_halt_level_two;
        logic       light_halt_level;
        logic       light_exit_by_reset;
        logic       wait_state;
        logic       debug_active;
    } mtu_power_t;

    typedef struct packed {
        logic       overflow_flag;
        logic       overflow_irq_enable;
        logic       counter_halt;
        logic [1:0] source_select;
        logic [3:0] prescale_select;
        logic [7:0] modulo_limit;
    } mtu_cfg_t;
endpackage : mtu_pkg

/* logic/mtu_prescaler.sv */
`timescale 1ns/100ps
module mtu_prescaler
    import mtu_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Control
    input  wire logic       sync_clear,
    input  wire logic       src_tick,
    input  wire logic [3:0] prescale_select,
    // Result
    output logic            count_tick
);
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick_reg;
    logic       tick_next;

    function automatic logic [7:0] ratio_mask(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
        ratio_mask = 8'((9'h001 << s) - 9'h001);
    endfunction : ratio_mask

    always_comb begin
        div_next  = div_reg;
        tick_next = 1'b0;
        if (sync_clear) begin
            div_next = 8'h00;
        end else if (src_tick) begin
            // Divide by 1..256, out-of-range codes act as 256
            if ((div_reg & ratio_mask(prescale_select)) == ratio_mask(prescale_select)) begin
                div_next  = 8'h00;
                tick_next = 1'b1;
            end else begin
                div_next = 8'(div_reg + 8'h01);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign count_tick = tick_reg;

    tick_one_per_src_a : assert property (@(posedge clock) disable iff (!rst_n)
        tick_reg |-> $past(src_tick)) else $error("prescaler tick without source");
endmodule : mtu_prescaler

/* logic/mtu_timer.sv */
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module mtu_timer
    import mtu_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // System control
    input  wire logic        peripheral_clock_gate,
    input  wire logic        fixed_freq_clock,
    input  wire logic        ext_count_clock_pin,
    input  wire mtu_power_t  power_state,
    // Interrupt request
    output logic             irq
);
    mtu_cfg_t   cfg_reg,   cfg_next;
    logic [7:0] count_reg, count_next;
    logic       armed_reg, armed_next;
    logic [31:0] rdata_reg, rdata_next;
    logic       ack_reg,   ack_next;
    logic       irq_reg,   irq_next;
    logic [2:0] pin_sync_reg, fix_sync_reg;
    logic       wait_reg,  wait_next;
    logic       src_tick;
    logic       count_tick;
    logic       run;
    logic       reset_to_default;
    logic       wr_hit, rd_hit;

    // Two-flop synchronisers; third stage only for edge detection
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_reg <= 3'h0;
            fix_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_count_clock_pin};
            fix_sync_reg <= {fix_sync_reg[1:0], fixed_freq_clock};
        end
    end

    always_comb begin
        case (cfg_reg.source_select)
            SRC_FIXED:    src_tick = fix_sync_reg[1] & ~fix_sync_reg[2];
            SRC_PIN_RISE: src_tick = pin_sync_reg[1] & ~pin_sync_reg[2];
            SRC_PIN_FALL: src_tick = ~pin_sync_reg[1] & pin_sync_reg[2];
            default:      src_tick = 1'b1;
        endcase
    end

    // Pin is only read, so a second timer may share it freely.
    // Stop and debug both freeze counting; wait does not.
    assign run = peripheral_clock_gate & ~cfg_reg.counter_halt & ~power_state.debug_active
               & ~power_state.deep_halt_level_one & ~power_state.deep_halt_level_two
               & ~power_state.light_halt_level;

    // Deep stop wake or reset-exit from light stop.
    assign reset_to_default = power_state.deep_halt_level_one | power_state.deep_halt_level_two
                            | (power_state.light_halt_level & power_state.light_exit_by_reset);

    // Write lands only at the edge that sees waitrequest low
    assign wr_hit = avs_write & ack_reg & avs_byteenable[0];
    assign rd_hit = avs_read & ~ack_reg;

    mtu_prescaler i_mtu_prescaler (
        .clock           (clock),
        .rst_n           (rst_n),
        .sync_clear      (reset_to_default),
        .src_tick        (src_tick & run),
        .prescale_select (cfg_reg.prescale_select),
        .count_tick      (count_tick)
    );

    always_comb begin
        cfg_next   = cfg_reg;
        count_next = count_reg;
        armed_next = armed_reg;
        rdata_next = rdata_reg;
        ack_next   = 1'b0;
        if (count_tick && run) begin
            if (cfg_reg.modulo_limit != 8'h00 && count_reg == cfg_reg.modulo_limit) begin
                count_next = 8'h00;
            end else begin
                count_next = 8'(count_reg + 8'h01);
            end
        end
        if (rd_hit) begin
            ack_next   = 1'b1;
            rdata_next = 32'h0000_0000;
            case (avs_address)
                OFS_STATUS_CONTROL: begin
                    rdata_next[BIT_OVERFLOW_FLAG]   = cfg_reg.overflow_flag;
                    rdata_next[BIT_OVERFLOW_IRQ_EN] = cfg_reg.overflow_irq_enable;
                    rdata_next[BIT_COUNTER_HALT]    = cfg_reg.counter_halt; // reads back as written
                    if (cfg_reg.overflow_flag) begin
                        armed_next = 1'b1;
                    end
                end
                OFS_CLOCK_CONFIG:  rdata_next[5:0] = {cfg_reg.source_select,
                                                      cfg_reg.prescale_select};
                OFS_CURRENT_COUNT: rdata_next[7:0] = count_reg;
                OFS_MODULO_LIMIT:  rdata_next[7:0] = cfg_reg.modulo_limit;
                default:           rdata_next = 32'h0000_0000;
            endcase
        end else if (avs_write && !ack_reg) begin
            ack_next = 1'b1;
        end
        if (wr_hit) begin
            case (avs_address)
                OFS_STATUS_CONTROL: begin
                    cfg_next.overflow_irq_enable = avs_writedata[BIT_OVERFLOW_IRQ_EN];
                    cfg_next.counter_halt        = avs_writedata[BIT_COUNTER_HALT];
                    if (!avs_writedata[BIT_OVERFLOW_FLAG] && armed_reg) begin
                        cfg_next.overflow_flag = 1'b0;
                    end
                    armed_next = 1'b0;
                    if (avs_writedata[BIT_COUNTER_CLEAR]) begin
                        count_next             = RST_COUNT;
                        cfg_next.overflow_flag = 1'b0;
                    end
                end
                OFS_CLOCK_CONFIG: begin
                    // Counter kept across source or ratio change
                    cfg_next.source_select   = avs_writedata[POS_SOURCE_SELECT +: 2];
                    cfg_next.prescale_select = avs_writedata[3:0];
                end
                OFS_MODULO_LIMIT: begin
                    cfg_next.modulo_limit  = avs_writedata[7:0];
                    count_next             = RST_COUNT;
                    cfg_next.overflow_flag = 1'b0;
                end
                default: ;
            endcase
        end
        // Overflow set wins over any clear in the same cycle
        // Judged from the old count, so a clear in the wrap tick cycle still raises the flag
        if (count_tick && run && cfg_reg.modulo_limit != 8'h00
            && count_reg == cfg_reg.modulo_limit) begin
            cfg_next.overflow_flag = 1'b1;
        end
        if (count_tick && run && cfg_reg.modulo_limit == 8'h00 && count_reg == 8'hFF) begin
            cfg_next.overflow_flag = 1'b1;
        end
        if (reset_to_default) begin
            cfg_next   = '{default: 1'b0, counter_halt: 1'b1, modulo_limit: RST_MODULO};
            count_next = RST_COUNT;
            armed_next = 1'b0;
        end
        irq_next = cfg_next.overflow_flag & cfg_next.overflow_irq_enable;
        wait_next = ~ack_next;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg   <= '{default: 1'b0, counter_halt: 1'b1, modulo_limit: RST_MODULO};
            count_reg <= RST_COUNT;
            armed_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
            irq_reg   <= 1'b0;
            wait_reg  <= 1'b1;
        end else begin
            cfg_reg   <= cfg_next;
            count_reg <= count_next;
            armed_reg <= armed_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            irq_reg   <= irq_next;
            wait_reg  <= wait_next;
        end
    end

    // Waitrequest low one cycle after the request is seen
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign irq          = irq_reg;

    irq_level_a : assert property (@(posedge clock) disable iff (!rst_n)
        irq == (cfg_reg.overflow_flag & cfg_reg.overflow_irq_enable))
        else $error("irq level mismatch");
    halt_freezes_a : assert property (@(posedge clock) disable iff (!rst_n)
        $past(cfg_reg.counter_halt) && !$past(wr_hit) && !$past(reset_to_default)
        |-> $stable(count_reg)) else $error("count moved while halted");
    modulo_wrap_a : assert property (@(posedge clock) disable iff (!rst_n)
        count_tick && run && cfg_reg.modulo_limit != 8'h00
        && count_reg == cfg_reg.modulo_limit |=> count_reg == 8'h00 && cfg_reg.overflow_flag)
        else $error("modulo wrap missing");
    count_step_a : assert property (@(posedge clock) disable iff (!rst_n)
        count_tick && run && !wr_hit && !reset_to_default && count_reg != cfg_reg.modulo_limit
        |=> count_reg == 8'($past(count_reg) + 8'h01)) else $error("count step wrong");
    clear_zero_a : assert property (@(posedge clock) disable iff (!rst_n)
        wr_hit && avs_address == OFS_STATUS_CONTROL && avs_writedata[BIT_COUNTER_CLEAR]
        && !(count_tick && run) |=> count_reg == 8'h00 && !cfg_reg.overflow_flag)
        else $error("counter clear failed");
    stop_freeze_a : assert property (@(posedge clock) disable iff (!rst_n)
        power_state.light_halt_level && !power_state.light_exit_by_reset && !wr_hit
        |=> $stable(count_reg)) else $error("count moved in stop");
    deep_reset_a : assert property (@(posedge clock) disable iff (!rst_n)
        power_state.deep_halt_level_one |=> cfg_reg.counter_halt && count_reg == 8'h00)
        else $error("deep stop did not reset");
    gate_off_a : assert property (@(posedge clock) disable iff (!rst_n)
        !peripheral_clock_gate && !wr_hit && !reset_to_default |=> $stable(count_reg))
        else $error("count moved with clock gated");
    bus_answer_a : assert property (@(posedge clock) disable iff (!rst_n)
        (avs_read || avs_write) && !ack_reg |=> !avs_waitrequest)
        else $error("no bus answer");
    cover_overflow_c : cover property (@(posedge clock) $rose(cfg_reg.overflow_flag));
    cover_irq_c      : cover property (@(posedge clock) $rose(irq));
    cover_pin_c      : cover property (@(posedge clock)
        cfg_reg.source_select == SRC_PIN_FALL && count_tick);
endmodule : mtu_timer

/* sim/mtu_ext_clock.sv */
`timescale 1ns/100ps
module mtu_ext_clock (
    // Bus clock
    input  wire logic       clock,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] half_period,
    // Count pin
    output logic            pin
);
    logic [7:0] cnt;
    initial begin
        pin = 1'b0;
        cnt = 8'h00;
    end
    // Half period floored at 2 so the pin never outruns a quarter of bus rate
    always @(posedge clock) begin
        if (!run) begin
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= ((half_period < 8'h02) ? 8'h02 : half_period)) begin
            cnt <= 8'h00;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : mtu_ext_clock

/* sim/mtu_timer_bench.sv */
`timescale 1ns/100ps
module mtu_timer_bench;
    import mtu_pkg::*;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [3:0] adr;
        logic [7:0] wd;
        logic [3:0] be;
        logic [7:0] exp;
    } mtu_row_t;
    logic        clock;
    logic        rst_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        peripheral_clock_gate;
    logic        fixed_freq_clock;
    logic        ext_count_clock_pin;
    mtu_power_t  power_state;
    logic        irq;
    int          err_count;
    int          checks;
    int          cycles;
    logic [7:0]  rd;
    logic [7:0]  a;
    mtu_row_t    rows [7];
    logic [1:0]  srcs [3];
    logic [5:0]  deep [3];
    logic [7:0]  rst_exp [4];

    mtu_timer i_mtu_timer (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .peripheral_clock_gate(peripheral_clock_gate),
        .fixed_freq_clock(fixed_freq_clock), .ext_count_clock_pin(ext_count_clock_pin),
        .power_state(power_state), .irq(irq));
    mtu_ext_clock i_mtu_ext_clock (.clock(clock), .run(rst_n), .half_period(8'h04),
        .pin(ext_count_clock_pin));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Fixed clock at one eighth of bus rate; also the hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 3)
            fixed_freq_clock <= ~fixed_freq_clock;
        if (cycles == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    // Held until waitrequest is seen low; only the hang guard ends the wait
    task automatic access(input logic wr, input logic [3:0] adr, input logic [7:0] wd);
        @(posedge clock);
        avs_address    <= adr;
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_writedata  <= {24'h000000, wd};
        do
            @(posedge clock);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : access

    task automatic set_power(input logic [5:0] v);
        @(posedge clock);
        power_state <= v;
    endtask : set_power

    task automatic hold_check(input logic moving);
        access(1'b0, OFS_CURRENT_COUNT, 8'h00);
        a = rd;
        repeat (300) @(posedge clock);
        access(1'b0, OFS_CURRENT_COUNT, 8'h00);
        check({7'h00, rd !== a}, {7'h00, moving});
    endtask : hold_check

    task automatic period_run(input logic [7:0] cfg, input int lo, input int hi);
        int t0;
        access(1'b1, OFS_STATUS_CONTROL, 8'h10);
        access(1'b1, OFS_CLOCK_CONFIG, cfg);
        access(1'b1, OFS_MODULO_LIMIT, 8'h03);
        access(1'b1, OFS_STATUS_CONTROL, 8'h00);
        t0 = cycles;
        do
            access(1'b0, OFS_STATUS_CONTROL, 8'h00);
        while (rd[7] !== 1'b1);
        check({7'h00, (cycles - t0) >= lo && (cycles - t0) <= hi}, 8'h01);
    endtask : period_run

    initial begin
        int s;
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h1;
        peripheral_clock_gate = 1'b1;
        fixed_freq_clock = 1'b0;
        power_state = '0;
        err_count = 0;
        checks = 0;
        cycles = 0;
        rows = '{'{OFS_CLOCK_CONFIG, 8'hFF, 4'h1, 8'h3F}, '{OFS_CLOCK_CONFIG, 8'h12, 4'h0, 8'h3F},
            '{OFS_MODULO_LIMIT, 8'hA5, 4'h1, 8'hA5}, '{OFS_CURRENT_COUNT, 8'h77, 4'h1, 8'h00},
            '{OFS_STATUS_CONTROL, 8'hFF, 4'h1, 8'h50}, '{OFS_STATUS_CONTROL, 8'h10, 4'h1, 8'h10},
            '{4'h2, 8'hFF, 4'h1, 8'h00}};
        srcs = '{SRC_FIXED, SRC_PIN_FALL, SRC_PIN_RISE};
        deep = '{6'h20, 6'h10, 6'h0C};
        rst_exp = '{8'h10, 8'h00, 8'h00, 8'h00};
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            avs_byteenable <= rows[i].be;
            access(1'b1, rows[i].adr, rows[i].wd);
            avs_byteenable <= 4'h1;
            access(1'b0, rows[i].adr, 8'h00);
            check(rd, rows[i].exp);
        end
        for (int p = 0; p < 10; p++) begin
            s = (p > 8) ? 8 : p;
            period_run({2'b00, SRC_BUS, 4'(p)}, 3 << s, (4 << s) + 12);
        end
        foreach (srcs[k])
            period_run({2'b00, srcs[k], 4'h0}, 24, 48);
        access(1'b1, OFS_STATUS_CONTROL, 8'h90);
        access(1'b1, OFS_STATUS_CONTROL, 8'hD0);
        repeat (2) @(posedge clock);
        check({7'h00, irq}, 8'h01);
        access(1'b0, OFS_STATUS_CONTROL, 8'h00);
        check(rd, 8'hD0);
        access(1'b1, OFS_STATUS_CONTROL, 8'h50);
        access(1'b0, OFS_STATUS_CONTROL, 8'h00);
        check(rd, 8'h50);
        check({7'h00, irq}, 8'h00);
        access(1'b1, OFS_CLOCK_CONFIG, 8'h07);
        access(1'b1, OFS_MODULO_LIMIT, 8'h00);
        access(1'b1, OFS_STATUS_CONTROL, 8'h00);
        hold_check(1'b1);
        set_power(6'h02);
        hold_check(1'b1);
        set_power(6'h01);
        hold_check(1'b0);
        set_power(6'h00);
        hold_check(1'b1);
        peripheral_clock_gate <= 1'b0;
        hold_check(1'b0);
        peripheral_clock_gate <= 1'b1;
        set_power(6'h08);
        hold_check(1'b0);
        set_power(6'h00);
        hold_check(1'b1);
        access(1'b1, OFS_STATUS_CONTROL, 8'h10);
        hold_check(1'b0);
        set_power(6'h02);
        hold_check(1'b0);
        set_power(6'h00);
        // Halt kept with the clear so no prescaler tick can move the count
        access(1'b1, OFS_STATUS_CONTROL, 8'h30);
        access(1'b0, OFS_CURRENT_COUNT, 8'h00);
        check(rd, 8'h00);
        access(1'b0, OFS_STATUS_CONTROL, 8'h00);
        check(rd, 8'h10);
        foreach (deep[k]) begin
            access(1'b1, OFS_MODULO_LIMIT, 8'h55);
            set_power(deep[k]);
            set_power(6'h00);
            access(1'b0, OFS_STATUS_CONTROL, 8'h00);
            check(rd, 8'h10);
            access(1'b0, OFS_MODULO_LIMIT, 8'h00);
            check(rd, 8'h00);
        end
        access(1'b1, OFS_CLOCK_CONFIG, 8'h3F);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rst_exp[k]) begin
            access(1'b0, 4'(k * 4), 8'h00);
            check(rd, rst_exp[k]);
        end
        close_out();
    end
endmodule : mtu_timer_bench
